// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top import wdt_pkg::*;;
	// Clock, reset and bus drive
	logic pclk = 1'b0;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [apb_addr_w-1:0] paddr;
	logic [31:0] pwdata;
	logic ext_reset_pin;
	logic power_fail_pin;
	// Observed outputs
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic watchdog_reset_out;
	logic watchdog_irq_req;
	logic irq;
	// Bookkeeping
	int n_fail = 0;
	int checks = 0;
	int n_rst = 0;
	logic [31:0] rdv;
	logic errv;

	// Short time-out exponents keep the run brief; the 512-clock grace stays
	watchdog_with_timed_access #(.exp0(6), .exp1(7), .exp2(8), .exp3(9)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_reset_pin(ext_reset_pin), .power_fail_pin(power_fail_pin),
		.watchdog_reset_out(watchdog_reset_out), .watchdog_irq_req(watchdog_irq_req), .irq(irq));

	always #25 pclk = ~pclk;

	// Count watchdog reset pulses so silent periods can be judged later
	always @(posedge pclk) begin
		if (watchdog_reset_out === 1'b1) n_rst <= n_rst + 1;
	end

	task close_out;
		$display("Counts: checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task chk_rng(input string what, input int lo, input int hi, input int got);
		checks++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	// One APB transfer; request held until pready is seen high at a rising edge
	task bus(input logic [idx_w-1:0] idx, input logic wr, input logic [7:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 50) begin
				n_fail++;
				$display("[ERR] pready expected 1 seen %b", pready);
				close_out();
			end
			@(posedge pclk);
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [idx_w-1:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
	endtask

	task rdc(input string what, input logic [idx_w-1:0] idx, input logic [7:0] exp, input logic [7:0] m = 8'hff);
		bus(idx, 1'b0, 8'h00);
		chk(what, {24'h000000, exp & m}, rdv & {24'h000000, m});
	endtask

	task unlock;
		wr(idx_key, key_first);
		wr(idx_key, key_second);
	endtask

	// Cycles until the interrupt request (0) or the reset pulse (1) is seen
	task wait_sig(input bit which, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((which ? watchdog_reset_out : watchdog_irq_req) !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			n_fail++;
			$display("[ERR] wait for output %0d expected high seen low", which);
			close_out();
		end
	endtask

	task pin_pulse(input bit pf);
		@(posedge pclk);
		if (pf) power_fail_pin <= 1'b1;
		else ext_reset_pin <= 1'b1;
		repeat (2) @(posedge pclk);
		power_fail_pin <= 1'b0;
		ext_reset_pin <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask

	task t_reset;
		rdc("watchdog_control", idx_watchdog_control, 8'h40);
		rdc("clock_control", idx_clock_control, clock_control_reset);
		rdc("eie", idx_eie, 8'h00);
		rdc("key readback", idx_key, 8'h00);
		rdc("irq_status", idx_irq_status, 8'h00);
		bus(10'h3ff, 1'b0, 8'h00);
		chk("unmapped error", 32'h1, {31'h0, errv});
		chk("unmapped data", 32'h0, rdv);
		$display("done: reset values");
	endtask

	// Interrupt flag may be set by the early time-out here, so bit 3 is masked
	task t_protect;
		wr(idx_watchdog_control, 8'hff);
		rdc("free bits", idx_watchdog_control, 8'hf4, 8'hf7);
		wr(idx_watchdog_control, 8'h00);
		rdc("locked write", idx_watchdog_control, 8'h40, 8'hf7);
		unlock();
		wr(idx_watchdog_control, 8'h00);
		rdc("unlocked write", idx_watchdog_control, 8'h00, 8'hf7);
		wr(idx_key, key_first);
		wr(idx_key, 8'h12);
		wr(idx_watchdog_control, 8'h40);
		rdc("wrong second key", idx_watchdog_control, 8'h00, 8'hf7);
		wr(idx_key, key_first);
		wr(idx_clock_control, clock_control_reset);
		wr(idx_key, key_second);
		wr(idx_watchdog_control, 8'h40);
		rdc("interrupted sequence", idx_watchdog_control, 8'h00, 8'hf7);
		unlock();
		repeat (9) @(posedge pclk);
		wr(idx_watchdog_control, 8'h40);
		rdc("late in window", idx_watchdog_control, 8'h40, 8'hf7);
		unlock();
		repeat (12) @(posedge pclk);
		wr(idx_watchdog_control, 8'h00);
		rdc("window expired", idx_watchdog_control, 8'h40, 8'hf7);
		$display("done: protection");
	endtask

	// Descending codes so the running counter never meets a shorter limit early
	task t_timeout;
		int n;
		wr(idx_eie, 8'h10);
		wr(idx_irq_mask, 8'h01);
		for (int c = 3; c >= 0; c--) begin
			wr(idx_clock_control, {c[1:0], 6'h01});
			wr(idx_irq_status, 8'h01);
			unlock();
			wr(idx_watchdog_control, 8'h01);
			wait_sig(1'b0, n);
			chk_rng("time-out clocks", (1 << (6 + c)) - 2, (1 << (6 + c)) + 4, n);
			chk("irq on time-out", 32'h1, {31'h0, irq});
			wr(idx_irq_status, 8'h01);
			@(negedge pclk);
			chk("irq after clear", 32'h0, {31'h0, irq});
			chk("request held", 32'h1, {31'h0, watchdog_irq_req});
		end
		wr(idx_eie, 8'h00);
		@(negedge pclk);
		chk("request with enable off", 32'h0, {31'h0, watchdog_irq_req});
		rdc("flag without enable", idx_watchdog_control, 8'h08, 8'h08);
		$display("done: time-out codes");
	endtask

	task t_wdreset;
		int n;
		wr(idx_eie, 8'h10);
		unlock();
		wr(idx_watchdog_control, 8'h03);
		wait_sig(1'b0, n);
		wait_sig(1'b1, n);
		chk_rng("reset delay", 508, 516, n);
		@(posedge pclk);
		chk("reset pulse width", 32'h0, {31'h0, watchdog_reset_out});
		rdc("watchdog_control after reset", idx_watchdog_control, 8'h06);
		rdc("irq_status events", idx_irq_status, 8'h03);
		wr(idx_irq_mask, 8'h02);
		wr(idx_irq_status, 8'h02);
		@(negedge pclk);
		chk("masked irq", 32'h0, {31'h0, irq});
		wr(idx_irq_status, 8'h01);
		$display("done: watchdog reset");
	endtask

	task t_restart;
		int n0;
		n0 = n_rst;
		repeat (6) begin
			unlock();
			wr(idx_watchdog_control, 8'h03);
			repeat (40) @(posedge pclk);
		end
		chk("resets while kicked", n0, n_rst);
		rdc("restart self-clears", idx_watchdog_control, 8'h02, 8'hf7);
		$display("done: restart");
	endtask

	// Interrupt enable is off here, so the flag below shows a silent time-out
	task t_noewt;
		int n0;
		wr(idx_eie, 8'h00);
		unlock();
		wr(idx_watchdog_control, 8'h05);
		n0 = n_rst;
		repeat (700) @(posedge pclk);
		chk("resets with enable off", n0, n_rst);
		chk("quiet request", 32'h0, {31'h0, watchdog_irq_req});
		rdc("cause kept", idx_watchdog_control, 8'h0c);
		$display("done: reset disabled");
	endtask

	task t_pins;
		unlock();
		wr(idx_watchdog_control, 8'hfe);
		rdc("all set", idx_watchdog_control, 8'hfe);
		pin_pulse(1'b0);
		rdc("after external", idx_watchdog_control, 8'h56);
		pin_pulse(1'b1);
		rdc("after power-fail", idx_watchdog_control, 8'h52);
		unlock();
		wr(idx_watchdog_control, 8'h00);
		$display("done: reset pins");
	endtask

	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		ext_reset_pin = 1'b0;
		power_fail_pin = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_protect();
		t_timeout();
		t_wdreset();
		t_restart();
		t_noewt();
		t_pins();
		close_out();
	end

	// Hang guard well above the run length
	initial begin
		#5000000;
		n_fail++;
		$display("[ERR] run time expected below limit seen limit");
		close_out();
	end
endmodule // tb_top

// >>> timed_access.sv
`timescale 1ns/1ps
module timed_access import wdt_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link to the register core
	wdt_link_if.ta link
);
	typedef enum logic [1:0] {ta_idle = 2'b01, ta_armed = 2'b10} ta_state_t;
	ta_state_t state;
	ta_state_t next_state;
	logic [window_w-1:0] window;
	logic [window_w-1:0] next_window;
	logic [window_w:0] open_run;
	wire is_first = link.key_write && (link.wdata == key_first);
	wire is_second = link.key_write && (link.wdata == key_second);
	wire unlock = link.any_write && (state == ta_armed) && is_second;

	// Any mapped write breaks the sequence unless it is the first key
	always_comb begin
		next_state = state;
		if (link.any_write) begin
			next_state = is_first ? ta_armed : ta_idle;
		end
	end

	// Window counts down from unlock; reopening just reloads it
	assign next_window = unlock ? window_load : ((window != '0) ? window - 1'b1 : window);
	assign link.window_open = (window != '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ta_idle;
			window <= '0;
		end else begin
			state <= next_state;
			window <= next_window;
		end
	end

	// Helper: length of the current open run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_run <= '0;
		end else begin
			open_run <= unlock ? '0 : (link.window_open ? open_run + 1'b1 : '0);
		end
	end

	property p_unlock_opens;
		@(posedge pclk) disable iff (!presetn)
		unlock |=> link.window_open [*8];
	endproperty
	a_unlock_opens: assert property (p_unlock_opens) else $error("window not open after unlock");

	property p_window_bound;
		@(posedge pclk) disable iff (!presetn)
		link.window_open |-> (open_run < (window_w+1)'(window_clocks));
	endproperty
	a_window_bound: assert property (p_window_bound) else $error("window open too long");

	property p_abandon;
		@(posedge pclk) disable iff (!presetn)
		(state == ta_armed && link.any_write && !is_second && !link.window_open) |=> !link.window_open;
	endproperty
	a_abandon: assert property (p_abandon) else $error("wrong key opened window");
endmodule // timed_access

// >>> watchdog_with_timed_access.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module watchdog_with_timed_access import wdt_pkg::*; #(
	parameter int unsigned exp0 = tmo_exp_0,
	parameter int unsigned exp1 = tmo_exp_1,
	parameter int unsigned exp2 = tmo_exp_2,
	parameter int unsigned exp3 = tmo_exp_3
) (
	// Clock and power-on reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [apb_addr_w-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reset source pins, asynchronous, active high
	input wire logic ext_reset_pin,
	input wire logic power_fail_pin,
	// Watchdog outputs
	output logic watchdog_reset_out,
	output logic watchdog_irq_req,
	output logic irq
);
	localparam int n_pins = 2;
	wdt_link_if link ();
	logic [7:0] watchdog_control;
	logic [7:0] next_watchdog_control;
	logic [7:0] clock_control;
	logic [7:0] extended_interrupt_enable;
	logic [irq_w-1:0] irq_status;
	logic [irq_w-1:0] irq_mask;
	logic [irq_w-1:0] irq_events;
	logic [n_pins-1:0] pin_in;
	logic [n_pins-1:0] pin_rise;

	// Reset pins: three flops, a change counts once the last two agree
	assign pin_in = {power_fail_pin, ext_reset_pin};
	generate
		for (genvar g = 0; g < n_pins; g++) begin : g_pin
			logic s1;
			logic s2;
			logic s3;
			logic level;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					level <= 1'b0;
				end else begin
					s1 <= pin_in[g];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) level <= s3;
				end
			end
			assign pin_rise[g] = (s2 == s3) && s3 && !level;
		end
	endgenerate

	wire ext_evt = pin_rise[0];
	wire pf_evt = pin_rise[1];
	wire wdt_evt = link.wdt_reset;

	// APB decode: word index, zero wait states
	wire [idx_w-1:0] idx = paddr[apb_addr_w-1:2];
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_key = (idx == idx_key);
	wire hit_watchdog_control = (idx == idx_watchdog_control);
	wire hit_clock_control = (idx == idx_clock_control);
	wire hit_eie = (idx == idx_eie);
	wire hit_status = (idx == idx_irq_status);
	wire hit_mask = (idx == idx_irq_mask);
	wire mapped = hit_key || hit_watchdog_control || hit_clock_control || hit_eie || hit_status || hit_mask;
	wire wr = access && pwrite && mapped;
	wire wr_watchdog_control = wr && hit_watchdog_control;
	wire wr_clock_control = wr && hit_clock_control;
	wire wr_eie = wr && hit_eie;
	wire wr_status = wr && hit_status;
	wire wr_mask = wr && hit_mask;
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// Key register is write-only and reads as zero
	wire [31:0] rd_mux = hit_watchdog_control ? {24'h0, watchdog_control} :
		hit_clock_control ? {24'h0, clock_control} :
		hit_eie ? {24'h0, extended_interrupt_enable} :
		hit_status ? {30'h0, irq_status} :
		hit_mask ? {30'h0, irq_mask} : 32'h0;

	// Read data is captured in the setup cycle and stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// Every mapped write is seen by the unlock sequencer, key writes by value
	assign link.any_write = wr;
	assign link.key_write = wr && hit_key;
	assign link.wdata = pwdata[7:0];

	// Timer controls
	assign link.restart = watchdog_control[bit_rwt] || ext_evt || pf_evt;
	assign link.sel = clock_control[sel_hi:sel_lo];
	assign link.reset_enable = watchdog_control[bit_ewt];

	timed_access u_ta (
		.pclk(pclk),
		.presetn(presetn),
		.link(link)
	);

	wdt_timer #(
		.exp0(exp0),
		.exp1(exp1),
		.exp2(exp2),
		.exp3(exp3)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.link(link)
	);

	// Control register: write, hardware sets, then reset-source effects
	always_comb begin
		next_watchdog_control = watchdog_control;
		next_watchdog_control[bit_rwt] = 1'b0;
		if (wr_watchdog_control) begin
			next_watchdog_control = (pwdata[7:0] & ~watchdog_control_protect) |
				((link.window_open ? pwdata[7:0] : next_watchdog_control) & watchdog_control_protect);
		end
		// Set beats a software clear in the same cycle
		if (link.timeout) begin
			next_watchdog_control[bit_watchdog_interrupt_flag] = 1'b1;
		end
		if (ext_evt || pf_evt || wdt_evt) begin
			next_watchdog_control = next_watchdog_control & watchdog_control_ext_keep;
		end
		if (pf_evt) begin
			next_watchdog_control[bit_watchdog_reset_cause_flag] = 1'b0;
		end
		if (wdt_evt) begin
			next_watchdog_control[bit_watchdog_reset_cause_flag] = 1'b1;
		end
	end

	// Power-on is the async reset: power-up flag set, reset enable cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_control <= watchdog_control_por_value;
		end else begin
			watchdog_control <= next_watchdog_control;
		end
	end

	// Clock control and extended interrupt enable are plain storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_control <= clock_control_reset;
			extended_interrupt_enable <= eie_reset;
		end else begin
			if (wr_clock_control) clock_control <= pwdata[7:0];
			if (wr_eie) extended_interrupt_enable <= pwdata[7:0];
		end
	end

	// Interrupt request is the sticky flag gated by its enable bit, so it holds until either is cleared
	assign watchdog_irq_req = watchdog_control[bit_watchdog_interrupt_flag] && extended_interrupt_enable[bit_watchdog_interrupt_enable];

	// Reset pulse is registered so it is glitch free at the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_reset_out <= 1'b0;
		end else begin
			watchdog_reset_out <= wdt_evt;
		end
	end

	// Sticky event status, write one to clear, set wins
	assign irq_events = {wdt_evt, link.timeout};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq_mask <= '0;
		end else begin
			irq_status <= (irq_status & ~(wr_status ? pwdata[irq_w-1:0] : '0)) | irq_events;
			if (wr_mask) irq_mask <= pwdata[irq_w-1:0];
		end
	end
	assign irq = |(irq_status & irq_mask);

	property p_watchdog_interrupt_flag_set;
		@(posedge pclk) disable iff (!presetn)
		link.timeout && !wdt_evt |=> watchdog_control[bit_watchdog_interrupt_flag];
	endproperty
	a_watchdog_interrupt_flag_set: assert property (p_watchdog_interrupt_flag_set) else $error("time-out did not set flag");

	property p_irq_hold;
		@(posedge pclk) disable iff (!presetn)
		watchdog_irq_req && !wr_watchdog_control && !wr_eie && !ext_evt && !pf_evt && !wdt_evt |=> watchdog_irq_req;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("request dropped without clear");

	property p_protect;
		@(posedge pclk) disable iff (!presetn)
		wr_watchdog_control && !link.window_open && !ext_evt && !pf_evt && !wdt_evt
			|=> watchdog_control[bit_ewt] == $past(watchdog_control[bit_ewt]) && watchdog_control[bit_por] == $past(watchdog_control[bit_por]);
	endproperty
	a_protect: assert property (p_protect) else $error("protected bit written while locked");

	property p_watchdog_reset_cause_flag_set;
		@(posedge pclk) disable iff (!presetn)
		wdt_evt |=> watchdog_control[bit_watchdog_reset_cause_flag] && !watchdog_control[bit_watchdog_interrupt_flag];
	endproperty
	a_watchdog_reset_cause_flag_set: assert property (p_watchdog_reset_cause_flag_set) else $error("reset cause not set");

	property p_watchdog_reset_cause_flag_keep;
		@(posedge pclk) disable iff (!presetn)
		!watchdog_control[bit_ewt] && !wr_watchdog_control && !pf_evt |=> $stable(watchdog_control[bit_watchdog_reset_cause_flag]);
	endproperty
	a_watchdog_reset_cause_flag_keep: assert property (p_watchdog_reset_cause_flag_keep) else $error("reset cause moved while disabled");

	property p_pf_clear;
		@(posedge pclk) disable iff (!presetn)
		pf_evt && !wdt_evt |=> !watchdog_control[bit_watchdog_reset_cause_flag];
	endproperty
	a_pf_clear: assert property (p_pf_clear) else $error("power-fail kept reset cause");

	property p_ext_pattern;
		@(posedge pclk) disable iff (!presetn)
		ext_evt && !wdt_evt && !pf_evt |=> ((watchdog_control & ~watchdog_control_ext_keep) == 8'h00) && $stable(watchdog_control[bit_watchdog_reset_cause_flag])
			&& $stable(watchdog_control[bit_ewt]) && $stable(watchdog_control[bit_por]);
	endproperty
	a_ext_pattern: assert property (p_ext_pattern) else $error("external reset pattern wrong");

	property p_rwt_self_clear;
		@(posedge pclk) disable iff (!presetn)
		watchdog_control[bit_rwt] |=> !watchdog_control[bit_rwt] || $past(wr_watchdog_control);
	endproperty
	a_rwt_self_clear: assert property (p_rwt_self_clear) else $error("restart bit stuck");

	property p_por_sticky;
		@(posedge pclk) disable iff (!presetn)
		watchdog_control[bit_por] && !wr_watchdog_control |=> watchdog_control[bit_por];
	endproperty
	a_por_sticky: assert property (p_por_sticky) else $error("power-up flag lost");

	// Write masking, reset pulse and status cross-checks; events are excluded where they rewrite the image
	property p_free_bits;
		@(posedge pclk) disable iff (!presetn)
		wr_watchdog_control && !ext_evt && !pf_evt && !wdt_evt
			|=> (watchdog_control & ~watchdog_control_protect) == ($past(pwdata[7:0]) & ~watchdog_control_protect);
	endproperty
	a_free_bits: assert property (p_free_bits) else $error("free control bits not written");

	property p_open_write;
		@(posedge pclk) disable iff (!presetn)
		wr_watchdog_control && link.window_open && !link.timeout && !ext_evt && !pf_evt && !wdt_evt
			|=> (watchdog_control & watchdog_control_protect) == ($past(pwdata[7:0]) & watchdog_control_protect);
	endproperty
	a_open_write: assert property (p_open_write) else $error("protected bits not written in window");

	property p_locked_flags;
		@(posedge pclk) disable iff (!presetn)
		wr_watchdog_control && !link.window_open && !link.timeout && !ext_evt && !pf_evt && !wdt_evt
			|=> watchdog_control[bit_watchdog_interrupt_flag] == $past(watchdog_control[bit_watchdog_interrupt_flag]) && !watchdog_control[bit_rwt];
	endproperty
	a_locked_flags: assert property (p_locked_flags) else $error("locked write moved a guarded flag");

	property p_guarded_bits;
		@(posedge pclk) disable iff (!presetn)
		!link.window_open |=> $stable(watchdog_control[bit_ewt]) && $stable(watchdog_control[bit_por]);
	endproperty
	a_guarded_bits: assert property (p_guarded_bits) else $error("guarded bit changed while locked");

	property p_reset_gated;
		@(posedge pclk) disable iff (!presetn)
		watchdog_reset_out |-> $past(watchdog_control[bit_ewt]);
	endproperty
	a_reset_gated: assert property (p_reset_gated) else $error("reset pulse without reset enable");

	property p_reset_single;
		@(posedge pclk) disable iff (!presetn)
		watchdog_reset_out |=> !watchdog_reset_out;
	endproperty
	a_reset_single: assert property (p_reset_single) else $error("reset pulse longer than one clock");

	property p_reset_status;
		@(posedge pclk) disable iff (!presetn)
		wdt_evt |=> watchdog_reset_out && irq_status[irq_wdt_reset];
	endproperty
	a_reset_status: assert property (p_reset_status) else $error("reset event not reported");

	property p_timeout_status;
		@(posedge pclk) disable iff (!presetn)
		link.timeout |=> irq_status[irq_timeout];
	endproperty
	a_timeout_status: assert property (p_timeout_status) else $error("time-out not reported");

	property p_pin_once;
		@(posedge pclk) disable iff (!presetn)
		(pin_rise & $past(pin_rise)) == '0;
	endproperty
	a_pin_once: assert property (p_pin_once) else $error("pin event seen twice");

	property p_read_image;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && hit_watchdog_control |=> prdata == {24'h0, $past(watchdog_control)};
	endproperty
	a_read_image: assert property (p_read_image) else $error("control read data not captured");
endmodule // watchdog_with_timed_access

// >>> wdt_link_if.sv
`timescale 1ns/1ps
interface wdt_link_if;
	// Unlock path
	logic any_write;
	logic key_write;
	logic [7:0] wdata;
	logic window_open;
	// Timer path
	logic restart;
	logic [1:0] sel;
	logic reset_enable;
	logic timeout;
	logic wdt_reset;
	modport ta (input any_write, input key_write, input wdata, output window_open);
	modport timer (input restart, input sel, input reset_enable, output timeout, output wdt_reset);
	modport core (output any_write, output key_write, output wdata, input window_open,
		output restart, output sel, output reset_enable, input timeout, input wdt_reset);
endinterface

// >>> wdt_pkg.sv
package wdt_pkg;
	// Bus geometry and register indexes (byte address is four times the index)
	localparam int apb_addr_w = 12;
	localparam int idx_w = 10;
	localparam logic [idx_w-1:0] idx_key = 10'h0c7;
	localparam logic [idx_w-1:0] idx_watchdog_control = 10'h0d8;
	localparam logic [idx_w-1:0] idx_clock_control = 10'h08e;
	localparam logic [idx_w-1:0] idx_eie = 10'h0e8;
	localparam logic [idx_w-1:0] idx_irq_status = 10'h100;
	localparam logic [idx_w-1:0] idx_irq_mask = 10'h101;
	// Unlock keys and window timing
	localparam logic [7:0] key_first = 8'haa;
	localparam logic [7:0] key_second = 8'h55;
	localparam int machine_cycle_clocks = 4;
	localparam int window_machine_cycles = 3;
	localparam int window_clocks = machine_cycle_clocks * window_machine_cycles;
	localparam int window_w = 4;
	localparam logic [window_w-1:0] window_load = window_w'(window_clocks);
	// Watchdog counter and reset grace
	localparam int wdt_cnt_w = 26;
	localparam int reset_delay_clocks = 512;
	localparam int grace_w = 9;
	localparam logic [grace_w-1:0] grace_last = grace_w'(reset_delay_clocks - 1);
	localparam int unsigned tmo_exp_0 = 17;
	localparam int unsigned tmo_exp_1 = 20;
	localparam int unsigned tmo_exp_2 = 23;
	localparam int unsigned tmo_exp_3 = 26;
	// Control register fields
	localparam int bit_por = 6;
	localparam int bit_watchdog_interrupt_flag = 3;
	localparam int bit_watchdog_reset_cause_flag = 2;
	localparam int bit_ewt = 1;
	localparam int bit_rwt = 0;
	localparam logic [7:0] watchdog_control_protect = 8'h4b;
	localparam logic [7:0] watchdog_control_ext_keep = 8'h56;
	localparam logic [7:0] watchdog_control_por_value = 8'h40;
	localparam int sel_hi = 7;
	localparam int sel_lo = 6;
	localparam logic [7:0] clock_control_reset = 8'h01;
	localparam int bit_watchdog_interrupt_enable = 4;
	localparam logic [7:0] eie_reset = 8'h00;
	// Interrupt status layout
	localparam int irq_w = 2;
	localparam int irq_timeout = 0;
	localparam int irq_wdt_reset = 1;
endpackage

// >>> wdt_timer.sv
`timescale 1ns/1ps
module wdt_timer import wdt_pkg::*; #(
	parameter int unsigned exp0 = tmo_exp_0,
	parameter int unsigned exp1 = tmo_exp_1,
	parameter int unsigned exp2 = tmo_exp_2,
	parameter int unsigned exp3 = tmo_exp_3
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link to the register core
	wdt_link_if.timer link
);
	typedef enum logic [1:0] {tm_run = 2'b01, tm_grace = 2'b10} tm_state_t;
	localparam logic [wdt_cnt_w-1:0] masks [4] = '{
		wdt_cnt_w'((64'd1 << exp0) - 64'd1), wdt_cnt_w'((64'd1 << exp1) - 64'd1),
		wdt_cnt_w'((64'd1 << exp2) - 64'd1), wdt_cnt_w'((64'd1 << exp3) - 64'd1)};
	tm_state_t state;
	tm_state_t next_state;
	logic [wdt_cnt_w-1:0] count;
	logic [grace_w-1:0] grace;
	logic [9:0] since;
	wire [wdt_cnt_w-1:0] tap_mask = masks[link.sel];
	wire grace_end = (state == tm_grace) && (grace == grace_last);

	// Time-out at the selected tap; reset only if enabled at grace end
	assign link.timeout = (state == tm_run) && (count == tap_mask) && !link.restart;
	assign link.wdt_reset = grace_end && link.reset_enable && !link.restart;

	always_comb begin
		next_state = state;
		unique case (state)
			tm_run: if (link.timeout) next_state = tm_grace;
			tm_grace: if (grace_end) next_state = tm_run;
		endcase
		if (link.restart) begin
			next_state = tm_run;
		end
	end

	// Counter runs freely; restart or own reset clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= tm_run;
			count <= '0;
			grace <= '0;
		end else begin
			state <= next_state;
			count <= (link.restart || link.wdt_reset) ? '0 : count + 1'b1;
			grace <= (state == tm_grace && !link.restart) ? grace + 1'b1 : '0;
		end
	end

	// Helper: clocks since the last time-out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since <= '1;
		end else begin
			since <= link.timeout ? '0 : ((since != '1) ? since + 1'b1 : since);
		end
	end

	property p_reset_delay;
		@(posedge pclk) disable iff (!presetn)
		link.wdt_reset |-> (since == 10'(reset_delay_clocks - 1));
	endproperty
	a_reset_delay: assert property (p_reset_delay) else $error("reset not 512 clocks after time-out");

	property p_reset_enabled;
		@(posedge pclk) disable iff (!presetn)
		link.wdt_reset |-> link.reset_enable;
	endproperty
	a_reset_enabled: assert property (p_reset_enabled) else $error("reset while disabled");

	property p_restart_clears;
		@(posedge pclk) disable iff (!presetn)
		link.restart |=> (count == '0) && (state == tm_run);
	endproperty
	a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear");

	property p_tap;
		@(posedge pclk) disable iff (!presetn)
		link.timeout |-> (count == masks[link.sel]) && ($past(count) + 1'b1 == count || $past(link.restart));
	endproperty
	a_tap: assert property (p_tap) else $error("time-out at wrong count");
endmodule // wdt_timer
